/* shared/l1_act_pkg.sv */
/*
 * Shared definitions for the terminal-side layer-1 activation state machine:
 * command and indication codes, line signal codes, register map, timing.
 * Assumes a 250 MHz system clock and an AXI4-Lite register bus.
 */
package l1_act_pkg;

    // Upstream commands (4 bits)
    localparam logic [3:0] CMD_TIMING       = 4'h0;
    localparam logic [3:0] CMD_SOFT_RESET   = 4'h1;
    localparam logic [3:0] CMD_SINGLE_PULSE = 4'h2;
    localparam logic [3:0] CMD_CONT_PULSE   = 4'h4;
    localparam logic [3:0] CMD_ACT_PRIO_LO  = 4'h8;
    localparam logic [3:0] CMD_ACT_PRIO_HI  = 4'h9;
    localparam logic [3:0] CMD_LOOP_REQ     = 4'ha;
    localparam logic [3:0] CMD_DEACT_UP     = 4'hf;

    // Downstream indications (4 bits)
    localparam logic [3:0] IND_DEACT_REQ    = 4'h0;
    localparam logic [3:0] IND_LEVEL_UNSYNC = 4'h4;
    localparam logic [3:0] IND_ERROR        = 4'h6;
    localparam logic [3:0] IND_POWER_UP     = 4'h7;
    localparam logic [3:0] IND_ACT_REQ_DOWN = 4'h8;
    localparam logic [3:0] IND_TEST         = 4'ha;
    localparam logic [3:0] IND_AWAKE_TEST   = 4'hb;
    localparam logic [3:0] IND_ACT_PRIO_LO  = 4'hc;
    localparam logic [3:0] IND_ACT_PRIO_HI  = 4'hd;
    localparam logic [3:0] IND_DEACT_DOWN   = 4'hf;

    // Line signal codes, received and transmitted
    localparam logic [2:0] INFO0 = 3'h0;
    localparam logic [2:0] INFO1 = 3'h1;
    localparam logic [2:0] INFO2 = 3'h2;
    localparam logic [2:0] INFO3 = 3'h3;
    localparam logic [2:0] INFO4 = 3'h4;

    // Transmit pattern modes
    localparam logic [1:0] TXM_INFO      = 2'h0;
    localparam logic [1:0] TXM_CONT      = 2'h1;
    localparam logic [1:0] TXM_SINGLE    = 2'h2;

    // Register byte offsets
    localparam logic [3:0] OFF_CMD    = 4'h0;
    localparam logic [3:0] OFF_IND    = 4'h4;
    localparam logic [3:0] OFF_CTRL   = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hc;

    // Reset values and field positions
    localparam logic [3:0] CMD_RESET_VAL  = 4'hf;
    localparam logic       STOP_SEL_RESET_VAL = 1'b0;
    localparam int         CTRL_STOP_SEL_BIT  = 0;
    localparam int         STAT_NEW_BIT   = 4;
    localparam int         STAT_XFER_BIT  = 5;
    localparam int         STAT_CLK_BIT   = 6;
    localparam int         STAT_LOOP_BIT  = 7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int CLK_MHZ            = 250;
    localparam int DEACT_FLYWHEEL_US  = 16000;
    localparam int DEACT_FLYWHEEL_CYC = DEACT_FLYWHEEL_US * CLK_MHZ;
    localparam int POWER_UP_MIN_US    = 500;
    localparam int POWER_UP_MIN_CYC   = POWER_UP_MIN_US * CLK_MHZ;
    localparam int SINGLE_PULSE_HZ    = 2000;
    localparam int SINGLE_PULSE_CYC   = CLK_MHZ * 1000000 / SINGLE_PULSE_HZ;
    localparam int DEACT_DOWN_FRAMES  = 4;
    localparam int DEACT_FLYWHEEL_FRAMES = 64;

    typedef enum {
        ST_RESET,
        ST_F3_PDOWN,
        ST_F3_PUP,
        ST_F3_PEND_DEACT,
        ST_F4_PEND_ACT,
        ST_F5_UNSYNC,
        ST_F6_SYNC,
        ST_F7_ACT,
        ST_F8_LOST,
        ST_LOOP_CLOSED,
        ST_LOOP_ACT,
        ST_TEST_CONT,
        ST_TEST_SINGLE
    } l1_state_t;

    typedef struct packed {
        logic [2:0] info;
        logic       frame_sync;
        logic       frame_tick;
    } line_rx_t;

    typedef struct packed {
        logic [2:0] info;
        logic [1:0] mode;
        logic       pulse;
        logic       loopback;
        logic       awake_en;
    } line_tx_t;

endpackage

/* rtl/te_layer1_activation_fsm.sv */
/*
 * Terminal-side layer-1 activation/deactivation state machine with an
 * AXI4-Lite register slave for command, indication, control and status.
 * Assumes the line receiver delivers decoded signal codes, sync and a
 * per-frame tick synchronous to aclk.
 */
// Overview of operation
// - Indicate power-up with clocks; deactivate request code
// - Error indication on soft reset, or on reset pin in power-down with clock-stop select clear
// - Level-unsync on signal; act-request on INFO2
// - Test indication; awake-test when level during loop
// - INFO4 with low priority gives 1100
// - INFO4 with high priority gives 1101
// - Announce clock stop with 1111
// - Awake detector armed except reset; clocks stop on select
// - Timing command or bus request powers up, delayed
// - 64 INFO0 frames before pending deactivation
// - Pending deactivation: line activation only, deact-up powers down
// - Pending activation sends INFO1, stays indefinitely
// - Non-INFO0 signal stops INFO1, enters unsynchronized
// - INFO2 answered with INFO3, synchronized
// - INFO4 reaches activated quickly
// - Lost framing awaits INFO2, INFO4 or INFO0
// - Loop request loops INFO3 internally, also sends INFO3
// - Looped sync allows data, test or awake-test
// - Continuous pulses, or single pulses at 2 kHz
// - Soft reset idles analog, INFO0, detector off
// - Commands via command register; indications readable
module te_layer1_activation_fsm (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [3:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [3:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                hw_reset_pin,
    input  wire logic                bus_request_line_n,
    input  wire logic                osc_running,
    input  wire l1_act_pkg::line_rx_t line_rx,
    output l1_act_pkg::line_tx_t     line_tx,
    output logic                     clock_enable,
    output logic                     data_xfer_en,
    output logic                     status_event
);

    l1_act_pkg::l1_state_t state_reg;
    l1_act_pkg::l1_state_t state_next;
    logic [3:0]  cmd_reg;
    logic        cmd_new_reg;
    logic        clk_stop_sel_reg;
    logic        prio_hi_reg;
    logic        act_req_reg;
    logic [3:0]  ind_reg;
    logic [3:0]  ind_next;
    logic        ind_new_reg;
    logic [6:0]  info0_frames_reg;
    logic [26:0] pwr_cnt_reg;
    logic        pwr_done_reg;
    logic [2:0]  dd_frames_reg;
    logic [18:0] pulse_cnt_reg;
    logic        pulse_reg;
    logic        clk_en_reg;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [3:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic        w_strb0_reg;
    logic        rd_ind_pulse;
    logic        do_write;
    logic        level;

    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == l1_act_pkg::OFF_CMD) || (a == l1_act_pkg::OFF_IND) ||
                 (a == l1_act_pkg::OFF_CTRL) || (a == l1_act_pkg::OFF_STATUS);
    endfunction

    assign level = (line_rx.info != l1_act_pkg::INFO0);
    assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign rd_ind_pulse = s_axi_arvalid && s_axi_arready &&
                          (s_axi_araddr == l1_act_pkg::OFF_IND);

    // Write channel capture, either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 4'h0;
            w_data_reg    <= 32'h0;
            w_strb0_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= l1_act_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg  <= 1'b1;
                w_data_reg  <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_reg) ? l1_act_pkg::RESP_OKAY
                                                    : l1_act_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Command and control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmd_reg     <= l1_act_pkg::CMD_RESET_VAL;
            cmd_new_reg <= 1'b0;
            clk_stop_sel_reg <= l1_act_pkg::STOP_SEL_RESET_VAL;
        end
        else
        begin
            cmd_new_reg <= 1'b0;
            if (do_write && w_strb0_reg)
            begin
                if (aw_addr_reg == l1_act_pkg::OFF_CMD)
                begin
                    cmd_reg     <= w_data_reg[3:0];
                    cmd_new_reg <= 1'b1;
                end
                if (aw_addr_reg == l1_act_pkg::OFF_CTRL)
                begin
                    clk_stop_sel_reg <= w_data_reg[l1_act_pkg::CTRL_STOP_SEL_BIT];
                end
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= l1_act_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= mapped(s_axi_araddr) ? l1_act_pkg::RESP_OKAY
                                                      : l1_act_pkg::RESP_SLVERR;
                case (s_axi_araddr)
                    l1_act_pkg::OFF_CMD:    s_axi_rdata <= {28'h0, cmd_reg};
                    l1_act_pkg::OFF_IND:    s_axi_rdata <= {28'h0, ind_reg};
                    l1_act_pkg::OFF_CTRL:   s_axi_rdata <= {31'h0, clk_stop_sel_reg};
                    l1_act_pkg::OFF_STATUS: s_axi_rdata <= {24'h0, line_tx.loopback,
                                                clk_en_reg, act_req_reg, ind_new_reg, ind_reg};
                    default:                s_axi_rdata <= 32'h0;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Priority and data-transfer permission
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prio_hi_reg <= 1'b0;
            act_req_reg <= 1'b0;
        end
        else if (cmd_new_reg)
        begin
            if (cmd_reg == l1_act_pkg::CMD_ACT_PRIO_LO || cmd_reg == l1_act_pkg::CMD_ACT_PRIO_HI)
            begin
                prio_hi_reg <= (cmd_reg == l1_act_pkg::CMD_ACT_PRIO_HI);
                act_req_reg <= 1'b1;
            end
            else if (cmd_reg != l1_act_pkg::CMD_TIMING)
            begin
                act_req_reg <= 1'b0;
            end
        end
    end

    // INFO0 flywheel, frames counted in every state while no signal
    always_ff @(posedge aclk)
    begin
        if (!aresetn || level)
        begin
            info0_frames_reg <= 7'h0;
        end
        else if (line_rx.frame_tick &&
                 info0_frames_reg != 7'(l1_act_pkg::DEACT_FLYWHEEL_FRAMES))
        begin
            info0_frames_reg <= info0_frames_reg + 7'd1;
        end
    end

    // Power-up delay once oscillator runs
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_reg != l1_act_pkg::ST_F3_PUP || !osc_running)
        begin
            pwr_cnt_reg  <= 27'h0;
            pwr_done_reg <= 1'b0;
        end
        else if (pwr_cnt_reg == 27'(l1_act_pkg::POWER_UP_MIN_CYC - 1))
        begin
            pwr_done_reg <= 1'b1;
        end
        else
        begin
            pwr_cnt_reg <= pwr_cnt_reg + 27'd1;
        end
    end

    // Frames of deactivate-down before clocks stop
    always_ff @(posedge aclk)
    begin
        if (!aresetn || ind_reg != l1_act_pkg::IND_DEACT_DOWN)
        begin
            dd_frames_reg <= 3'h0;
        end
        else if (line_rx.frame_tick && dd_frames_reg != 3'(l1_act_pkg::DEACT_DOWN_FRAMES))
        begin
            dd_frames_reg <= dd_frames_reg + 3'd1;
        end
    end

    // Single-pulse 2 kHz generator
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_reg != l1_act_pkg::ST_TEST_SINGLE)
        begin
            pulse_cnt_reg <= 19'h0;
            pulse_reg     <= 1'b0;
        end
        else if (pulse_cnt_reg == 19'(l1_act_pkg::SINGLE_PULSE_CYC - 1))
        begin
            pulse_cnt_reg <= 19'h0;
            pulse_reg     <= 1'b1;
        end
        else
        begin
            pulse_cnt_reg <= pulse_cnt_reg + 19'd1;
            pulse_reg     <= 1'b0;
        end
    end

    // Next state
    always_comb
    begin
        state_next = state_reg;
        if (cmd_new_reg && cmd_reg == l1_act_pkg::CMD_SOFT_RESET)
            state_next = l1_act_pkg::ST_RESET;
        else if (cmd_new_reg && cmd_reg == l1_act_pkg::CMD_LOOP_REQ)
            state_next = l1_act_pkg::ST_LOOP_CLOSED;
        else if (cmd_new_reg && cmd_reg == l1_act_pkg::CMD_CONT_PULSE)
            state_next = l1_act_pkg::ST_TEST_CONT;
        else if (cmd_new_reg && cmd_reg == l1_act_pkg::CMD_SINGLE_PULSE)
            state_next = l1_act_pkg::ST_TEST_SINGLE;
        else
        begin
            case (state_reg)
                l1_act_pkg::ST_RESET,
                l1_act_pkg::ST_LOOP_CLOSED,
                l1_act_pkg::ST_LOOP_ACT,
                l1_act_pkg::ST_TEST_CONT,
                l1_act_pkg::ST_TEST_SINGLE:
                begin
                    if (state_reg == l1_act_pkg::ST_LOOP_CLOSED && line_rx.frame_sync)
                        state_next = l1_act_pkg::ST_LOOP_ACT;
                    if (cmd_new_reg && cmd_reg == l1_act_pkg::CMD_DEACT_UP)
                        state_next = l1_act_pkg::ST_F3_PDOWN;
                end
                l1_act_pkg::ST_F3_PDOWN,
                l1_act_pkg::ST_F3_PUP:
                begin
                    if (level && !hw_reset_pin)
                        state_next = l1_act_pkg::ST_F5_UNSYNC;
                    else if (cmd_new_reg && (cmd_reg == l1_act_pkg::CMD_ACT_PRIO_LO ||
                             cmd_reg == l1_act_pkg::CMD_ACT_PRIO_HI))
                        state_next = l1_act_pkg::ST_F4_PEND_ACT;
                    else if ((cmd_new_reg && cmd_reg == l1_act_pkg::CMD_TIMING) ||
                             !bus_request_line_n)
                        state_next = l1_act_pkg::ST_F3_PUP;
                    else if (cmd_new_reg && cmd_reg == l1_act_pkg::CMD_DEACT_UP)
                        state_next = l1_act_pkg::ST_F3_PDOWN;
                end
                l1_act_pkg::ST_F3_PEND_DEACT:
                begin
                    if (level)
                        state_next = l1_act_pkg::ST_F5_UNSYNC;
                    else if (cmd_new_reg && cmd_reg == l1_act_pkg::CMD_DEACT_UP)
                        state_next = l1_act_pkg::ST_F3_PDOWN;
                end
                l1_act_pkg::ST_F4_PEND_ACT:
                begin
                    if (level)
                        state_next = l1_act_pkg::ST_F5_UNSYNC;
                end
                l1_act_pkg::ST_F5_UNSYNC,
                l1_act_pkg::ST_F6_SYNC,
                l1_act_pkg::ST_F7_ACT,
                l1_act_pkg::ST_F8_LOST:
                begin
                    if (info0_frames_reg == 7'(l1_act_pkg::DEACT_FLYWHEEL_FRAMES))
                        state_next = l1_act_pkg::ST_F3_PEND_DEACT;
                    else if (line_rx.info == l1_act_pkg::INFO4 && line_rx.frame_sync)
                        state_next = l1_act_pkg::ST_F7_ACT;
                    else if (line_rx.info == l1_act_pkg::INFO2 && line_rx.frame_sync)
                        state_next = l1_act_pkg::ST_F6_SYNC;
                    else if (state_reg != l1_act_pkg::ST_F5_UNSYNC && !line_rx.frame_sync)
                        state_next = l1_act_pkg::ST_F8_LOST;
                end
                default: state_next = l1_act_pkg::ST_F3_PDOWN;
            endcase
        end
    end

    // Indication for the next state
    always_comb
    begin
        ind_next = ind_reg;
        case (state_next)
            l1_act_pkg::ST_RESET:         ind_next = l1_act_pkg::IND_ERROR;
            l1_act_pkg::ST_F3_PDOWN:
                if (hw_reset_pin && !clk_stop_sel_reg)
                    ind_next = l1_act_pkg::IND_ERROR;
                else if (clk_stop_sel_reg)
                    ind_next = l1_act_pkg::IND_DEACT_DOWN;
                else
                    ind_next = l1_act_pkg::IND_DEACT_REQ;
            l1_act_pkg::ST_F3_PUP:
                ind_next = pwr_done_reg ? l1_act_pkg::IND_POWER_UP : ind_reg;
            l1_act_pkg::ST_F3_PEND_DEACT: ind_next = l1_act_pkg::IND_DEACT_REQ;
            l1_act_pkg::ST_F4_PEND_ACT:   ind_next = l1_act_pkg::IND_POWER_UP;
            l1_act_pkg::ST_F5_UNSYNC,
            l1_act_pkg::ST_F8_LOST:       ind_next = l1_act_pkg::IND_LEVEL_UNSYNC;
            l1_act_pkg::ST_F6_SYNC:       ind_next = l1_act_pkg::IND_ACT_REQ_DOWN;
            l1_act_pkg::ST_F7_ACT:
                ind_next = prio_hi_reg ? l1_act_pkg::IND_ACT_PRIO_HI
                                       : l1_act_pkg::IND_ACT_PRIO_LO;
            l1_act_pkg::ST_LOOP_ACT:
                ind_next = level ? l1_act_pkg::IND_AWAKE_TEST : l1_act_pkg::IND_TEST;
            l1_act_pkg::ST_TEST_CONT:     ind_next = l1_act_pkg::IND_TEST;
            default:                      ind_next = ind_reg;
        endcase
    end

    // State, indication and new-code flag
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg   <= l1_act_pkg::ST_F3_PDOWN;
            ind_reg     <= l1_act_pkg::IND_DEACT_REQ;
            ind_new_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ind_reg   <= ind_next;
            if (ind_next != ind_reg)
                ind_new_reg <= 1'b1;
            else if (rd_ind_pulse)
                ind_new_reg <= 1'b0;
        end
    end

    // Line transmitter, clocks and data permission
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_tx      <= '0;
            clk_en_reg   <= 1'b1;
            data_xfer_en <= 1'b0;
            status_event <= 1'b0;
        end
        else
        begin
            line_tx.info     <= (state_next == l1_act_pkg::ST_F4_PEND_ACT) ? l1_act_pkg::INFO1
                              : (state_next == l1_act_pkg::ST_F6_SYNC ||
                                 state_next == l1_act_pkg::ST_F7_ACT ||
                                 state_next == l1_act_pkg::ST_LOOP_ACT ||
                                 state_next == l1_act_pkg::ST_LOOP_CLOSED) ? l1_act_pkg::INFO3
                              : l1_act_pkg::INFO0;
            line_tx.loopback <= (state_next == l1_act_pkg::ST_LOOP_CLOSED ||
                                 state_next == l1_act_pkg::ST_LOOP_ACT);
            line_tx.mode     <= (state_next == l1_act_pkg::ST_TEST_CONT) ? l1_act_pkg::TXM_CONT
                              : (state_next == l1_act_pkg::ST_TEST_SINGLE) ? l1_act_pkg::TXM_SINGLE
                              : l1_act_pkg::TXM_INFO;
            line_tx.pulse    <= pulse_reg;
            line_tx.awake_en <= !hw_reset_pin && state_next != l1_act_pkg::ST_RESET;
            clk_en_reg       <= !(state_reg == l1_act_pkg::ST_F3_PDOWN && clk_stop_sel_reg &&
                                  dd_frames_reg == 3'(l1_act_pkg::DEACT_DOWN_FRAMES) &&
                                  !level && bus_request_line_n);
            data_xfer_en     <= act_req_reg && (state_next == l1_act_pkg::ST_F7_ACT ||
                                state_next == l1_act_pkg::ST_LOOP_ACT);
            status_event     <= ind_next != ind_reg;
        end
    end

    assign clock_enable = clk_en_reg;

endmodule

/* test/fsm_checker.sv */
/* Port assertions for the activation block.
   Bound to every instance of the block; sees its ports only. */
module fsm_checker (
    input wire logic                 aclk, aresetn, hw_reset_pin,
    input wire logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic                 s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic [1:0]           s_axi_rresp,
    input wire l1_act_pkg::line_rx_t line_rx,
    input wire l1_act_pkg::line_tx_t line_tx
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == l1_act_pkg::RESP_SLVERR
        |-> s_axi_rdata == 32'h0)
        else $error("error read not zero");
    info1_stop_a: assert property (line_tx.info == l1_act_pkg::INFO1 && line_rx.info != 3'h0
        |-> ##[1:3] line_tx.info != l1_act_pkg::INFO1)
        else $error("INFO1 kept on signal");
    loop_info3_a: assert property (line_tx.loopback |-> line_tx.info == l1_act_pkg::INFO3)
        else $error("loop not sending INFO3");
    awake_off_a: assert property (hw_reset_pin [*3] |-> !line_tx.awake_en)
        else $error("detector on in reset");
    info3_answer_a: assert property ((line_rx.info == l1_act_pkg::INFO2 && line_rx.frame_sync) [*4]
        |-> ##[1:8] line_tx.info == l1_act_pkg::INFO3)
        else $error("INFO2 not answered");
endmodule
bind te_layer1_activation_fsm fsm_checker chk (.aclk, .aresetn, .hw_reset_pin, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .line_rx, .line_tx);

/* test/nt_line_model.sv */
/* Network terminator seen through the line receiver.
   Sends the requested signal code; frame tick every 16 cycles.
   Receiver syncs on the internal loop while loop is high. */
module nt_line_model (
    input  wire logic           aclk,
    input  wire logic [2:0]     send,
    input  wire logic           loop,
    output l1_act_pkg::line_rx_t line_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg = 4'h0;
    always_ff @(posedge aclk)
    begin
        cnt_reg <= cnt_reg + 4'h1;
        line_rx.info <= send;
        line_rx.frame_sync <= (send != 3'h0) || loop;
        line_rx.frame_tick <= (cnt_reg == 4'hf);
    end
endmodule

/* test/tb_te_layer1_activation_fsm.sv */
/* Register-level tests of the activation block.
   Assumes the line model above and a 250 MHz clock. */
`define CK(a, b) n_checks++; if ((a) !== (b)) begin num_errors++; $display("CHECK FAILED %0t %h %h", $time, a, b); end
module tb_te_layer1_activation_fsm;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic hw_rst = 0, awready, wready, bvalid, arready, rvalid, ce, dx, se;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] send = 0;
    l1_act_pkg::line_rx_t line_rx;
    l1_act_pkg::line_tx_t line_tx;
    int num_errors = 0, n_checks = 0, cyc = 0, ev_cnt = 0;
    te_layer1_activation_fsm uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .hw_reset_pin(hw_rst), .bus_request_line_n(1'b1),
        .osc_running(1'b1), .line_rx(line_rx), .line_tx(line_tx), .clock_enable(ce),
        .data_xfer_en(dx), .status_event(se));
    nt_line_model nt (.aclk(aclk), .send(send), .loop(line_tx.loopback), .line_rx(line_rx));
    initial forever #2 aclk = ~aclk;
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin @(posedge aclk); if (awready) awvalid <= 0; if (wready) wvalid <= 0; end while (!bvalid);
        bready <= 0;
        repeat (10) @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin @(posedge aclk); if (arready) arvalid <= 0; end while (!rvalid);
        rready <= 0;
        `CK(rdata, e)
    endtask
    task automatic results();
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (se) ev_cnt++;
        if (cyc == 20000) begin num_errors++; results(); end
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rd(4'h4, 32'h0);
        rd(4'h0, 32'hf);
        rd(4'h1, 32'h0);
        `CK(rresp, 2'h2)
        wr(4'h0, 32'h8);
        `CK(bresp, 2'h0)
        `CK(line_tx.info, 3'h1)
        rd(4'h4, 32'h7);
        send <= 3'h2; repeat (40) @(posedge aclk);
        `CK(line_tx.info, 3'h3)
        rd(4'h4, 32'h8);
        send <= 3'h4; repeat (40) @(posedge aclk);
        rd(4'h4, 32'hc);
        `CK(dx, 1'b1)
        send <= 3'h0; repeat (960) @(posedge aclk);
        rd(4'h4, 32'h4);
        repeat (130) @(posedge aclk);
        rd(4'h4, 32'h0);
        wr(4'h0, 32'h9);
        `CK(line_tx.info, 3'h0)
        send <= 3'h4; repeat (60) @(posedge aclk);
        rd(4'h4, 32'hd);
        send <= 3'h0; repeat (1150) @(posedge aclk);
        wr(4'h8, 32'h1);
        wr(4'h0, 32'hf);
        repeat (100) @(posedge aclk);
        rd(4'h4, 32'hf);
        `CK(ce, 1'b0)
        wr(4'h8, 32'h0);
        hw_rst <= 1; repeat (10) @(posedge aclk);
        rd(4'h4, 32'h6);
        `CK(line_tx.awake_en, 1'b0)
        hw_rst <= 0;
        wr(4'h0, 32'h1);
        rd(4'h4, 32'h6);
        `CK(line_tx.awake_en, 1'b0)
        wr(4'h0, 32'hf);
        wr(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        wr(4'h0, 32'ha);
        `CK(line_tx.loopback, 1'b1)
        rd(4'h4, 32'ha);
        send <= 3'h4; repeat (4) @(posedge aclk);
        rd(4'h4, 32'hb);
        wr(4'h0, 32'h4);
        `CK(line_tx.mode, 2'h1)
        rd(4'h4, 32'ha);
        wr(4'h0, 32'h2);
        `CK(line_tx.mode, 2'h2)
        `CK(ev_cnt, 19)
        results();
    end
endmodule
